// ---- local_memory_bus_master_pkg.sv ----
// Constants and carrier types for the local-memory bus master.
// Assumes one 250 MHz system clock; the local-bus clock is a sampled pin.
// Notes on behaviour
// - Low extended line: page bit1, page bit2, then parity.
// - All bus timing follows local-bus clock one.
// - Buffer enable low only in data phase.
// - Master the bus only after grant seen.
// - Assert shared request when access is needed.
// - Defer while another requester holds request.
// - Column strobe low for 3/16 after row.
// - No column strobe in register ranges.
// - ROM bit set: no column strobe in ROM.
// - Direction high write, low read, set early.
// - Output enable low on DRAM reads only.
// - Row strobe low for first 5/16 of cycle.
// - Memory-bus reset: init logic, float outputs.
// - Request line only pulled low or released.
// - High byte: address, status, then data.
// - Address latch strobe falls at cycle start; here it is high for step 0 and falls after.
// - Write strobe low only on writes, data valid.
package local_memory_bus_master_pkg;

  // Phase steps of one memory cycle
  localparam logic [3:0] PH_ROW_LAST = 4'h4;   // Row interval 0..4
  localparam logic [3:0] PH_COL_FIRST = 4'h5;  // Column interval 5..7
  localparam logic [3:0] PH_COL_LAST = 4'h7;
  localparam logic [3:0] PH_Q2_FIRST = 4'h4;   // Second quarter start
  localparam logic [3:0] PH_DATA_FIRST = 4'h8; // Second half start
  localparam logic [3:0] PH_WR_FIRST = 4'h9;   // Write strobe window
  localparam logic [3:0] PH_WR_LAST = 4'he;
  localparam logic [3:0] PH_LAST = 4'hf;       // Last step of the cycle

  // Address ranges as byte addresses (page.offset)
  localparam logic [20:0] REG_RANGE_LO = 21'h010100;
  localparam logic [20:0] REG_RANGE_HI = 21'h0102ff;
  localparam logic [4:0] ROM_PAGE_LO = 5'h00;
  localparam logic [4:0] ROM_PAGE_HI = 5'h1f;
  localparam logic [15:0] ROM_OFF_MAX = 16'hfffe;

  // Status byte codes and parity sense
  localparam logic [7:0] STATUS_READ = 8'h00;
  localparam logic [7:0] STATUS_WRITE = 8'h80;
  localparam logic PARITY_ODD = 1'b1;

  // Reset values of the pin filters
  localparam logic [20:0] PIN_FILT_RESET = 21'h000000;

  // Request from the user side
  typedef struct packed {
    logic write;         // High for a write cycle
    logic [19:0] addr;   // Word address, page in the top five bits
    logic [15:0] wdata;  // Write data, bit 15 is bus bit 0
  } mem_req_t;

  // Answer to the user side
  typedef struct packed {
    logic [15:0] rdata;  // Read data
    logic parityErr;     // Low-byte parity mismatch on read
  } mem_rsp_t;

  // Sequencer states
  typedef enum logic [3:0] {
    ST_IDLE = 4'b0001,
    ST_PEND = 4'b0010,
    ST_REQ = 4'b0100,
    ST_RUN = 4'b1000
  } bus_state_t;

endpackage

// ---- local_memory_bus_master.sv ----
// Local-memory bus master: arbitration and one multiplexed memory cycle.
// Assumes bus pins are joined outside from the output enables given here.
`timescale 1ns/1ps
module local_memory_bus_master
  import local_memory_bus_master_pkg::*;
#(
  parameter int ADDR_BITS = 20
)(
  // System clock and reset
  input wire logic sys_clk,
  input wire logic sys_rst,
  // User request side
  input wire logic reqValid,
  input wire mem_req_t req,
  output logic reqReady,
  output logic rspValid,
  output mem_rsp_t rsp,
  input wire logic romEnable,
  // Bus clock, reset and arbitration pins
  input wire logic localBusClockOne,
  input wire logic memoryBusReset,
  input wire logic busGrantIn,
  input wire logic sharedBusRequestIn,
  output logic sharedBusRequestOut,
  output logic sharedBusRequestOe,
  // Multiplexed address/data pins
  input wire logic [7:0] addrDataHighByteIn,
  output logic [7:0] addrDataHighByteOut,
  output logic addrDataHighByteOe,
  input wire logic [7:0] addrDataLowByteIn,
  output logic [7:0] addrDataLowByteOut,
  output logic addrDataLowByteOe,
  input wire logic extAddrParityLowIn,
  output logic extAddrParityLowOut,
  output logic extAddrParityLowOe,
  // Strobes and buffer controls
  output logic addressLatchStrobe,
  output logic rowStrobeN,
  output logic columnStrobeN,
  output logic memOutputEnableN,
  output logic writeStrobeN,
  output logic bufferEnableN,
  output logic dataDirection,
  output logic ctrlOe
);

  // Refuse address widths the decode cannot serve
  if (ADDR_BITS != 20)
  begin : g_bad_width
    $error("ADDR_BITS must be 20");
  end

  // Three-stage pin synchronisers and agreement filter, 21 pin bits
  logic [20:0] pinS1_q, pinS2_q, pinS3_q, pinFilt_q;
  logic [20:0] pinRaw;
  assign pinRaw = {localBusClockOne, memoryBusReset, busGrantIn,
                   sharedBusRequestIn, addrDataHighByteIn,
                   addrDataLowByteIn, extAddrParityLowIn};

  // A bit changes only when the second and third stage agree
  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
    begin
      pinS1_q <= PIN_FILT_RESET;
      pinS2_q <= PIN_FILT_RESET;
      pinS3_q <= PIN_FILT_RESET;
      pinFilt_q <= PIN_FILT_RESET;
    end
    else
    begin
      pinS1_q <= pinRaw;
      pinS2_q <= pinS1_q;
      pinS3_q <= pinS2_q;
      pinFilt_q <= (pinS2_q & pinS3_q) | (pinFilt_q & (pinS2_q | pinS3_q));
    end
  end

  // Filtered pin views
  logic busClkF, busRstF, grantF, reqLineF, parInF;
  logic [7:0] highInF, lowInF;
  assign {busClkF, busRstF, grantF, reqLineF, highInF, lowInF, parInF} =
    pinFilt_q;

  // Rising edge of the filtered bus clock
  logic busClkPrev_q;
  logic busRise;
  assign busRise = busClkF & ~busClkPrev_q;

  logic anyRst;
  assign anyRst = sys_rst | busRstF;

  always_ff @(posedge sys_clk)
  begin
    if (anyRst)
      busClkPrev_q <= 1'b0;
    else
      busClkPrev_q <= busClkF;
  end

  // Sequencer state, phase and held request
  bus_state_t state_q;
  logic [3:0] phase_q;
  mem_req_t cur_q;

  always_ff @(posedge sys_clk)
  begin
    if (anyRst)
    begin
      state_q <= ST_IDLE;
      phase_q <= 4'h0;
    end
    else
    begin
      case (state_q)
        ST_IDLE:
          // Take a new request
          if (reqValid)
            state_q <= ST_PEND;
        ST_PEND:
          if (reqLineF)
            state_q <= ST_REQ;
        ST_REQ:
          // start at a bus edge after grant
          if (grantF && busRise)
          begin
            state_q <= ST_RUN;
            phase_q <= 4'h0;
          end
        ST_RUN:
          if (busRise)
          begin
            phase_q <= phase_q + 4'h1;
            if (phase_q == PH_LAST)
              state_q <= ST_IDLE;
          end
        default:
          state_q <= ST_IDLE;
      endcase
    end
  end

  // Capture the request when it is taken
  always_ff @(posedge sys_clk)
  begin
    if (anyRst)
      cur_q <= '0;
    else if (state_q == ST_IDLE && reqValid)
      cur_q <= req;
  end

  // Address decode on byte address
  logic [20:0] byteAddr;
  logic [4:0] page;
  logic [15:0] offs;
  logic inRegRange, inRomRange, noColumn;
  assign byteAddr = {cur_q.addr, 1'b0};
  assign page = byteAddr[20:16];
  assign offs = byteAddr[15:0];
  assign inRegRange = (byteAddr >= REG_RANGE_LO) &&
                      (byteAddr <= REG_RANGE_HI);
  assign inRomRange = (page == ROM_PAGE_LO || page == ROM_PAGE_HI) &&
                      (offs <= ROM_OFF_MAX);
  assign noColumn = inRegRange | (romEnable & inRomRange);

  // Phase decode
  logic running, inQ1, inQ2, inData;
  assign running = (state_q == ST_RUN);
  assign inQ1 = phase_q < PH_Q2_FIRST;
  assign inQ2 = !inQ1 && phase_q < PH_DATA_FIRST;
  assign inData = phase_q >= PH_DATA_FIRST;

  // Parity of the low data byte
  logic parOut;
  assign parOut = ^cur_q.wdata[7:0] ^ PARITY_ODD;

  // Registered strobes; all released under reset
  always_ff @(posedge sys_clk)
  begin
    if (anyRst)
    begin
      ctrlOe <= 1'b0;
      addressLatchStrobe <= 1'b0;
      rowStrobeN <= 1'b1;
      columnStrobeN <= 1'b1;
      memOutputEnableN <= 1'b1;
      writeStrobeN <= 1'b1;
      bufferEnableN <= 1'b1;
      dataDirection <= 1'b0;
    end
    else
    begin
      ctrlOe <= running;
      // latch high in step 0, falls after
      addressLatchStrobe <= running && phase_q == 4'h0;
      rowStrobeN <= !(running && phase_q <= PH_ROW_LAST);
      // column strobe for 3/16 after row
      columnStrobeN <= !(running && !noColumn &&
                         phase_q >= PH_COL_FIRST &&
                         phase_q <= PH_COL_LAST);
      // DRAM output enable on plain reads
      memOutputEnableN <= !(running && !cur_q.write && inData &&
                            !noColumn);
      // write strobe inside the data phase
      writeStrobeN <= !(running && cur_q.write &&
                        phase_q >= PH_WR_FIRST &&
                        phase_q <= PH_WR_LAST);
      // buffers on only in data phase
      bufferEnableN <= !(running && inData);
      dataDirection <= running && cur_q.write;
    end
  end

  // Multiplexed address, status and data pins
  always_ff @(posedge sys_clk)
  begin
    if (anyRst)
    begin
      addrDataHighByteOut <= 8'h00;
      addrDataLowByteOut <= 8'h00;
      extAddrParityLowOut <= 1'b0;
      addrDataHighByteOe <= 1'b0;
      addrDataLowByteOe <= 1'b0;
      extAddrParityLowOe <= 1'b0;
    end
    else
    begin
      // Address phases always driven, data only on writes
      addrDataHighByteOe <= running && (!inData || cur_q.write);
      addrDataLowByteOe <= running && (!inData || cur_q.write);
      extAddrParityLowOe <= running && (!inData || cur_q.write);
      if (inQ1)
      begin
        addrDataHighByteOut <= {page[0], offs[15:9]};
        addrDataLowByteOut <= offs[8:1];
        extAddrParityLowOut <= page[1];
      end
      else if (inQ2)
      begin
        addrDataHighByteOut <= cur_q.write ? STATUS_WRITE : STATUS_READ;
        addrDataLowByteOut <= {page[0], offs[15:9]};
        extAddrParityLowOut <= page[2];
      end
      else
      begin
        // write data held through data phase
        addrDataHighByteOut <= cur_q.wdata[15:8];
        addrDataLowByteOut <= cur_q.wdata[7:0];
        extAddrParityLowOut <= parOut;
      end
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (anyRst)
      sharedBusRequestOe <= 1'b0;
    else
      sharedBusRequestOe <= (state_q == ST_REQ) ||
                            (running && !(busRise && phase_q == PH_LAST));
  end
  assign sharedBusRequestOut = 1'b0;

  // User handshake and read capture at the last step
  always_ff @(posedge sys_clk)
  begin
    if (anyRst)
    begin
      reqReady <= 1'b0;
      rspValid <= 1'b0;
      rsp <= '0;
    end
    else
    begin
      reqReady <= (state_q == ST_IDLE) && !reqValid;
      rspValid <= running && busRise && phase_q == PH_LAST;
      if (running && busRise && phase_q == PH_LAST && !cur_q.write)
      begin
        rsp.rdata <= {highInF, lowInF};
        rsp.parityErr <= parInF != (^lowInF ^ PARITY_ODD);
      end
    end
  end

endmodule

// ---- local_memory_bus_master_assertions.sv ----
// Pin-level checker for the local-memory bus master.
// Assumes it is bound to the top module and sees only its ports.
`timescale 1ns/1ps
module local_memory_bus_master_assertions (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic memoryBusReset,
  // Pins under watch
  input wire logic busGrantIn,
  input wire logic sharedBusRequestOut,
  input wire logic sharedBusRequestOe,
  input wire logic ctrlOe,
  input wire logic addrDataLowByteOe,
  input wire logic [7:0] addrDataHighByteOut,
  input wire logic [7:0] addrDataLowByteOut,
  input wire logic extAddrParityLowOut,
  input wire logic addressLatchStrobe,
  input wire logic rowStrobeN,
  input wire logic columnStrobeN,
  input wire logic memOutputEnableN,
  input wire logic writeStrobeN,
  input wire logic bufferEnableN,
  input wire logic dataDirection
);
  // All checks on the system clock
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (sys_rst);
  chk_req_open_collector:
    assert property (sharedBusRequestOe |-> !sharedBusRequestOut)
    else $error("request line driven high");
  // Reset itself is the cause here, so no disable
  chk_reset_floats_pins:
    assert property (disable iff (1'b0) sys_rst |=> !ctrlOe
      && !sharedBusRequestOe && !addrDataLowByteOe)
    else $error("pins driven during reset");
  // Bus reset pin needs four edges to pass the pin filter and a fifth to float the pins
  chk_bus_reset_floats:
    assert property (memoryBusReset [*5] |=> !ctrlOe
      && !sharedBusRequestOe && !addrDataLowByteOe)
    else $error("pins driven during bus reset");
  chk_row_needs_grant:
    assert property ($fell(rowStrobeN) |-> busGrantIn && addressLatchStrobe)
    else $error("cycle started without grant");
  chk_column_after_row:
    assert property ($fell(columnStrobeN) |-> $rose(rowStrobeN))
    else $error("column strobe not right after row");
  chk_buffer_data_only:
    assert property (!bufferEnableN |-> rowStrobeN && columnStrobeN)
    else $error("buffer enabled in address phase");
  chk_dir_before_enable:
    assert property ($fell(bufferEnableN) |-> $stable(dataDirection))
    else $error("direction changed as buffer enabled");
  chk_write_data_valid:
    assert property (!writeStrobeN |-> dataDirection && !bufferEnableN
      && $stable(addrDataHighByteOut) && $stable(addrDataLowByteOut))
    else $error("write strobe without stable write data");
  chk_oe_reads_only:
    assert property (!memOutputEnableN |-> !dataDirection && !bufferEnableN)
    else $error("output enable outside a read data phase");
  chk_low_parity_odd:
    assert property (!bufferEnableN && dataDirection |->
      extAddrParityLowOut == ~^addrDataLowByteOut)
    else $error("wrong low byte parity");
  // Main scenarios reached
  cov_write: cover property ($fell(writeStrobeN));
  cov_read: cover property ($fell(memOutputEnableN));
  cov_cycle: cover property ($fell(rowStrobeN) ##5 !rowStrobeN);
endmodule

// ---- bus_partner_model.sv ----
// Far side: bus clock, arbiter, rival requester and DRAM.
// Assumes the bench feeds pinIn back to the block's pin inputs.
`timescale 1ns/1ps
module bus_partner_model #(
  parameter logic [15:0] RD = 16'ha55a  // Word returned on reads
)(
  // Clock and test controls
  input wire logic sys_clk,
  input wire logic other,
  input wire logic badPar,
  // Block pins seen from outside
  input wire logic reqOe,
  input wire logic oeN,
  input wire logic [2:0] pinOe,
  input wire logic [16:0] pinOut,
  // Levels seen by the block
  output logic busClk = 1'b0,
  output logic grant = 1'b0,
  output logic reqLine,
  output logic [16:0] pinIn
);
  logic [2:0] div = 3'h0;  // Bus clock divider
  logic flip = 1'b0;       // Floating bus pattern
  logic [16:0] mem;        // Far-side bus value
  always_ff @(posedge sys_clk)
  begin
    div <= (div == 3'h4) ? 3'h0 : div + 3'h1;
    flip <= !flip;
    if (div == 3'h4)
      busClk <= !busClk;
  end
  always_ff @(posedge sys_clk)
    grant <= reqOe && !other;
  assign reqLine = !(reqOe || other);
  // Undriven bus flips each cycle, never holds stale data
  assign mem = !oeN ? {RD, (~^RD[7:0]) ^ badPar} : {17{flip}};
  assign pinIn[16:9] = pinOe[2] ? pinOut[16:9] : mem[16:9];
  assign pinIn[8:1] = pinOe[1] ? pinOut[8:1] : mem[8:1];
  assign pinIn[0] = pinOe[0] ? pinOut[0] : mem[0];
endmodule

// ---- tb.sv ----
// Self-checking bench for the local-memory bus master.
// Assumes the partner model stands for every far-side device.
`timescale 1ns/1ps
module tb;
  import local_memory_bus_master_pkg::*;
  localparam logic [15:0] RD = 16'ha55a;
  localparam logic [15:0] WDATA = RD ^ 16'h0ff0;
  // System clocks per bus clock period, as the partner model makes it
  localparam int BUS_PER = 10;
  logic sys_clk = 0, sys_rst = 1, reqValid = 0, romEnable = 0;
  logic memoryBusReset = 0, other = 0, badPar = 0;
  mem_req_t req = '0;
  mem_rsp_t rsp;
  logic reqReady, rspValid, localBusClockOne, busGrantIn, ctrlOe;
  logic sharedBusRequestIn, sharedBusRequestOut, sharedBusRequestOe;
  logic [7:0] addrDataHighByteIn, addrDataHighByteOut;
  logic [7:0] addrDataLowByteIn, addrDataLowByteOut;
  logic addrDataHighByteOe, addrDataLowByteOe, extAddrParityLowIn;
  logic extAddrParityLowOut, extAddrParityLowOe, addressLatchStrobe;
  logic rowStrobeN, columnStrobeN, memOutputEnableN, writeStrobeN;
  logic bufferEnableN, dataDirection;
  logic [16:0] pinIn;
  logic [15:0] busWord;
  logic [4:0] pinOes;
  int err_total = 0, n_tests = 0, cyc = 0;
  local_memory_bus_master i_dut (.sys_clk, .sys_rst, .reqValid, .req,
    .reqReady, .rspValid, .rsp, .romEnable, .localBusClockOne,
    .memoryBusReset, .busGrantIn, .sharedBusRequestIn, .sharedBusRequestOut,
    .sharedBusRequestOe, .addrDataHighByteIn, .addrDataHighByteOut,
    .addrDataHighByteOe, .addrDataLowByteIn, .addrDataLowByteOut,
    .addrDataLowByteOe, .extAddrParityLowIn, .extAddrParityLowOut,
    .extAddrParityLowOe, .addressLatchStrobe, .rowStrobeN, .columnStrobeN,
    .memOutputEnableN, .writeStrobeN, .bufferEnableN, .dataDirection,
    .ctrlOe);
  bus_partner_model #(.RD(RD)) i_model (.sys_clk, .other, .badPar,
    .reqOe(sharedBusRequestOe), .oeN(memOutputEnableN),
    .pinOe({addrDataHighByteOe, addrDataLowByteOe, extAddrParityLowOe}),
    .pinOut({addrDataHighByteOut, addrDataLowByteOut, extAddrParityLowOut}),
    .busClk(localBusClockOne), .grant(busGrantIn),
    .reqLine(sharedBusRequestIn), .pinIn(pinIn));
  // Wire levels from all drivers
  assign {addrDataHighByteIn, addrDataLowByteIn, extAddrParityLowIn} = pinIn;
  assign busWord = {addrDataHighByteOut, addrDataLowByteOut};
  // Every output enable the block has, for the float checks
  assign pinOes = {ctrlOe, sharedBusRequestOe, addrDataHighByteOe,
                   addrDataLowByteOe, extAddrParityLowOe};
  initial
    forever #2 sys_clk = ~sys_clk;
  // Hang guard, far above the expected run
  always @(posedge sys_clk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      err_total++;
      final_report();
    end
  end
  task automatic check(input string what, input logic [16:0] exp, got);
    n_tests++;
    if (got !== exp)
    begin
      err_total++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic wait_ready();
    int n = 0;
    while (reqReady !== 1'b1 && n < 300)
    begin
      @(posedge sys_clk);
      #1 n++;
    end
    check("ready", 1, reqReady);
  endtask
  // One access; rival holds the request line for hold cycles
  task automatic run(input logic w, input logic [19:0] a,
    input logic ec, eo, input int hold);
    logic sc = 0, so = 0, sw = 0, early = 0;
    int n = 0, rowLow = 0, colLow = 0, latchHi = 0, colExp;
    other = (hold != 0);
    wait_ready();
    req = '{write: w, addr: a, wdata: WDATA};
    reqValid = 1;
    @(posedge sys_clk);
    #1 reqValid = 0;
    while (rspValid !== 1'b1 && n < 3000)
    begin
      if (n == hold)
        other = 0;
      early |= other && (sharedBusRequestOe || !rowStrobeN);
      if (!writeStrobeN && !sw)
        check("write data", WDATA, busWord);
      sc |= !columnStrobeN;
      so |= !memOutputEnableN;
      sw |= !writeStrobeN;
      // Strobe widths in system clocks, one sample per cycle
      rowLow += !rowStrobeN;
      colLow += !columnStrobeN;
      latchHi += addressLatchStrobe;
      @(posedge sys_clk);
      #1 n++;
    end
    check("response", 1, rspValid);
    // Last data step still stands when the response is seen
    check("buffer enable", 0, bufferEnableN);
    check("direction", w, dataDirection);
    check("row width", (PH_ROW_LAST + 1) * BUS_PER, rowLow);
    check("latch width", BUS_PER, latchHi);
    colExp = ec ? (PH_COL_LAST - PH_COL_FIRST + 1) * BUS_PER : 0;
    check("column width", colExp, colLow);
    check("column strobe", ec, sc);
    check("output enable", eo, so);
    check("write strobe", w, sw);
    check("deferral", 0, early);
    if (eo)
      check("read data", {RD, badPar}, rsp);
  endtask
  // Memory-bus reset in mid-cycle floats every pin
  task automatic bus_reset();
    wait_ready();
    req.write = 0;
    reqValid = 1;
    @(posedge sys_clk);
    #1 reqValid = 0;
    repeat (60) @(posedge sys_clk);
    // The cycle must be under way, or the float check proves nothing
    #1 check("busy", 1, ctrlOe);
    memoryBusReset = 1;
    repeat (8) @(posedge sys_clk);
    #1 check("float", 0, pinOes);
    memoryBusReset = 0;
  endtask
  task automatic final_report();
    $display("comparisons %0d mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  initial
  begin
    repeat (20) @(posedge sys_clk);
    #1 sys_rst = 0;
    run(0, 20'h10000, 1, 1, 0);
    run(1, 20'h10000, 1, 0, 0);
    run(0, {5'h01, 15'h0080}, 0, 0, 0);
    run(1, {5'h01, 15'h017f}, 0, 0, 0);
    run(0, {5'h01, 15'h007f}, 1, 1, 0);
    run(0, {5'h01, 15'h0180}, 1, 1, 0);
    run(0, 20'h00000, 1, 1, 0);
    romEnable = 1;
    run(0, 20'h00000, 0, 0, 0);
    run(0, 20'hfffff, 0, 0, 0);
    run(0, 20'h10000, 1, 1, 0);
    romEnable = 0;
    run(0, 20'h10000, 1, 1, 150);
    badPar = 1;
    run(0, 20'h10000, 1, 1, 0);
    badPar = 0;
    bus_reset();
    run(1, 20'h10000, 1, 0, 0);
    final_report();
  end
endmodule
bind local_memory_bus_master local_memory_bus_master_assertions i_chk (
  .sys_clk, .sys_rst, .memoryBusReset, .busGrantIn, .sharedBusRequestOut,
  .sharedBusRequestOe, .ctrlOe, .addrDataLowByteOe, .addrDataHighByteOut,
  .addrDataLowByteOut, .extAddrParityLowOut, .addressLatchStrobe,
  .rowStrobeN, .columnStrobeN, .memOutputEnableN, .writeStrobeN,
  .bufferEnableN, .dataDirection);
